// [msp_cfg_bank.sv]
// configuration bank and framing logic of the serial packet modem
// Functional notes
// - top bits pick protocol; reset selects packet
// - bit four picks text or binary form
// - bits three-two pick terminator kind
// - terminator ends packet, gathered data sent
// - second terminator code, or pair's last
// - first terminator code, or pair's first
// - source check drops foreign sender packets
// - destination check drops packets for others
// - destination 255 means broadcast to all
// - bit five disables broadcast reception in packet mode
// - master sends the group reference beacon
// - bit seven picks eight or seven bits
// - parity enable, even or odd select
// - bit four picks one or two stops
// - low nibble picks baud; reset 8N1 9600
// - command introduced by header or break
// - software or hardware flow control select
// - reception starts enabled or disabled
// - stream mode bit adds CR LF when set
// - packet mode bit suppresses CR LF when set
// - stream mode idle gap ends message
`include "msp_defines.svh"
`default_nettype none
module msp_cfg_bank import msp_pkg::*; #(
  parameter int TMO_UNIT_CYC = `MSP_TMO_UNIT_NS / `MSP_CLK_NS // per tick
) (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic nrst, // sync reset, low
  input wire logic sys_ce, // clock enable
  input wire logic cfg_wr, // register write
  input wire logic cfg_rd, // register read
  input wire logic [4:0] cfg_idx, // register number
  input wire logic [7:0] cfg_wdata, // write value
  output logic [7:0] cfg_rdata, // read value
  output logic cfg_rvalid, // read answer pulse
  output logic cfg_err, // bad register number
  input wire logic cmd_rx_enable, // reception enable command
  input wire logic cmd_rx_disable, // reception disable command
  input wire logic in_valid, // terminal byte offered
  input wire logic [7:0] in_data, // terminal byte
  output logic in_ready, // byte can be taken
  output logic tx_valid, // byte for radio
  output logic [7:0] tx_data, // byte value
  output logic tx_last, // byte ends packet
  input wire logic tx_ready, // radio side takes
  output logic tx_gap_end, // idle gap closed message
  input wire logic rx_hdr_valid, // received header present
  input wire logic [7:0] rx_hdr_src, // header sender address
  input wire logic [7:0] rx_hdr_dst, // header destination
  output logic rx_accept, // packet kept
  output logic rx_drop, // packet discarded
  output logic rx_enabled, // radio reception on
  output logic rx_add_crlf, // append CR LF on output
  output logic tx_binary, // binary transmit form
  output logic [1:0] proto_mode, // protocol in force
  output logic cmd_brk_hdr, // break introduces command
  output logic [7:0] cmd_hdr_char, // command header char
  output logic data_7bit, // seven data bits
  output logic parity_en, // parity bit present
  output logic parity_odd, // odd parity
  output logic stop_2bit, // two stop bits
  output logic [18:0] baud_div, // clocks per bit
  output logic baud_ok, // baud code valid
  output logic hw_flow, // RTS CTS pacing
  output logic master_beacon // send group beacon
);
  // ==========================================================
  // register cells
  logic [7:0] regs_w [0:`MSP_NREG-1]; // current cell values
  logic [7:0] r00, r02, r10, r16, r17; // addresses and codes
  logic [7:0] r18, r19, r20, r21, r22, r23, r26; // settings
  msp_proto_t proto_w; // protocol field
  msp_term_t term_w; // terminator field

  // reset value per register number
  function automatic logic [7:0] rst_val(input logic [4:0] idx);
    unique case (idx)
      5'h01: rst_val = `MSP_RV_01;
      5'h03: rst_val = `MSP_RV_03;
      5'h07: rst_val = `MSP_RV_07;
      5'h08: rst_val = `MSP_RV_08;
      5'h09: rst_val = `MSP_RV_09;
      5'h0a: rst_val = `MSP_RV_10;
      5'h0b: rst_val = `MSP_RV_11;
      5'h0c: rst_val = `MSP_RV_12;
      5'h0d: rst_val = `MSP_RV_13;
      5'h0e: rst_val = `MSP_RV_14;
      5'h10: rst_val = `MSP_RV_16;
      5'h11: rst_val = `MSP_RV_17;
      5'h12: rst_val = `MSP_RV_18; // packet, CR LF
      5'h14: rst_val = `MSP_RV_20; // 8N1 at 9600
      5'h15: rst_val = `MSP_RV_21;
      5'h18: rst_val = `MSP_RV_24;
      5'h19: rst_val = `MSP_RV_25;
      default: rst_val = `MSP_RV_ZERO;
    endcase
  endfunction

  // one cell per register number
  genvar gi;
  generate
    for (gi = 0; gi < `MSP_NREG; gi++) begin : g_cell
      logic [7:0] cell_reg; // stored value
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          cell_reg <= rst_val(5'(gi));
        end else if (sys_ce && cfg_wr && cfg_idx == 5'(gi)) begin
          cell_reg <= cfg_wdata; // reserved bits kept as written
        end
      end
      assign regs_w[gi] = cell_reg;
    end
  endgenerate

  assign r00 = regs_w[`MSP_IDX_LOCAL];
  assign r02 = regs_w[`MSP_IDX_DEST];
  assign r10 = regs_w[`MSP_IDX_CMDH];
  assign r16 = regs_w[`MSP_IDX_TERM1];
  assign r17 = regs_w[`MSP_IDX_TERM2];
  assign r18 = regs_w[`MSP_IDX_RADIO1];
  assign r19 = regs_w[`MSP_IDX_RADIO2];
  assign r20 = regs_w[`MSP_IDX_WIRED1];
  assign r21 = regs_w[`MSP_IDX_WIRED2];
  assign r22 = regs_w[`MSP_IDX_WIRED3];
  assign r23 = regs_w[`MSP_IDX_WIRED4];
  assign r26 = regs_w[`MSP_IDX_TMO];
  assign proto_w = msp_proto_t'(r18[`MSP_F_PROTO]);
  assign term_w = msp_term_t'(r18[`MSP_F_TERM]);

  // read answer, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
      cfg_err <= 1'b0;
    end else if (sys_ce) begin
      cfg_rvalid <= cfg_rd;
      cfg_err <= (cfg_rd || cfg_wr) && (cfg_idx >= 5'(`MSP_NREG));
      if (cfg_rd) begin
        // unmapped numbers read as zero
        cfg_rdata <= (cfg_idx < 5'(`MSP_NREG)) ? regs_w[cfg_idx] : 8'h00;
      end
    end
  end

  // ==========================================================
  // decoded settings
  // clocks per bit for a baud code
  function automatic logic [18:0] div_of(input logic [3:0] code);
    unique case (code)
      4'h0: div_of = 19'(`MSP_CLK_HZ / 300);
      4'h1: div_of = 19'(`MSP_CLK_HZ / 600);
      4'h2: div_of = 19'(`MSP_CLK_HZ / 1200);
      4'h3: div_of = 19'(`MSP_CLK_HZ / 2400);
      4'h4: div_of = 19'(`MSP_CLK_HZ / 4800);
      4'h5: div_of = 19'(`MSP_CLK_HZ / 9600);
      4'h6: div_of = 19'(`MSP_CLK_HZ / 19200);
      4'h7: div_of = 19'(`MSP_CLK_HZ / 38400);
      4'hc: div_of = 19'(`MSP_CLK_HZ / 57600);
      4'hd: div_of = 19'(`MSP_CLK_HZ / 115200);
      default: div_of = 19'h0; // reserved codes
    endcase
  endfunction

  // settings copied to output flops
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      proto_mode <= 2'h0;
      tx_binary <= 1'b0;
      master_beacon <= 1'b0;
      cmd_brk_hdr <= 1'b0;
      cmd_hdr_char <= 8'h00;
      hw_flow <= 1'b0;
    end else if (sys_ce) begin
      proto_mode <= proto_w;
      tx_binary <= r18[`MSP_B_FMT];
      master_beacon <= r19[`MSP_B_MASTER];
      cmd_brk_hdr <= r21[`MSP_B_BRKHDR];
      cmd_hdr_char <= r10;
      hw_flow <= r21[`MSP_B_HWFLOW];
    end
  end

  // serial character format and rate
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      data_7bit <= 1'b0;
      parity_en <= 1'b0;
      parity_odd <= 1'b0;
      stop_2bit <= 1'b0;
      baud_div <= 19'h0;
      baud_ok <= 1'b0;
    end else if (sys_ce) begin
      data_7bit <= r20[`MSP_B_DATA7];
      parity_en <= r20[`MSP_B_PAREN];
      // odd select is ignored without parity
      parity_odd <= r20[`MSP_B_PAREN] && r20[`MSP_B_PARODD];
      stop_2bit <= r20[`MSP_B_STOP2];
      baud_div <= div_of(r20[`MSP_F_BAUD]);
      baud_ok <= (div_of(r20[`MSP_F_BAUD]) != 19'h0);
    end
  end

  // CR LF addition depends on protocol
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_add_crlf <= 1'b0;
    end else if (sys_ce) begin
      unique case (proto_w)
        PROTO_STREAM: rx_add_crlf <= r23[`MSP_B_CRLF];
        PROTO_PACKET: rx_add_crlf <= !r23[`MSP_B_CRLF];
        default: rx_add_crlf <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // reception enable and packet filter
  logic rx_start_reg; // first cycle after reset
  logic src_bad, dst_bad, bc_bad, is_bc; // filter terms

  // initial state from setting, then commands
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_enabled <= 1'b0;
      rx_start_reg <= 1'b1;
    end else if (sys_ce) begin
      rx_start_reg <= 1'b0;
      if (rx_start_reg) begin
        rx_enabled <= !r22[`MSP_B_RXDIS];
      end else if (cmd_rx_enable) begin
        rx_enabled <= 1'b1;
      end else if (cmd_rx_disable) begin
        rx_enabled <= 1'b0;
      end
    end
  end

  assign is_bc = (rx_hdr_dst == `MSP_BCAST);
  assign src_bad = r18[`MSP_B_SRCCHK] && (rx_hdr_src != r02);
  assign dst_bad = r18[`MSP_B_DSTCHK] && !is_bc
                   && (rx_hdr_dst != r00);
  assign bc_bad = is_bc && (proto_w == PROTO_PACKET)
                  && r19[`MSP_B_BCDIS];

  // one verdict pulse per header
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_accept <= 1'b0;
      rx_drop <= 1'b0;
    end else if (sys_ce) begin
      rx_accept <= rx_hdr_valid && rx_enabled
                   && !(src_bad || dst_bad || bc_bad);
      rx_drop <= rx_hdr_valid
                 && (!rx_enabled || src_bad || dst_bad || bc_bad);
    end
  end

  // ==========================================================
  // terminal input path
  logic bo_valid; // buffer holds a byte
  logic [7:0] bo_data; // buffered byte
  logic bo_ready; // output stage free
  logic take; // byte moves to output
  logic is_end; // byte is terminator end
  logic term_use; // terminator framing active

  assign bo_ready = !tx_valid || tx_ready;
  assign take = bo_valid && bo_ready;
  // stream mode with a nonzero timeout frames by idle gap
  assign term_use = (proto_w != PROTO_STREAM) || (r26 == 8'h00);

  msp_pair_buf u_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sys_ce(sys_ce),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(bo_valid),
    .out_data(bo_data),
    .out_ready(bo_ready)
  );

  msp_term_det u_term (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sys_ce(sys_ce),
    .term_sel(term_w),
    .term1(r16),
    .term2(r17),
    .byte_valid(take),
    .byte_data(bo_data),
    .is_end(is_end)
  );

  // output stage toward the radio
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else if (sys_ce) begin
      if (take) begin
        tx_valid <= 1'b1;
        tx_data <= bo_data;
        tx_last <= term_use && is_end;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // idle gap timer for stream mode
  msp_gap_st_t gap_st_reg; // timer state
  logic [`MSP_PRE_W-1:0] pre_reg; // cycles within a tick
  logic [7:0] tick_reg; // ticks since last byte

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gap_st_reg <= GAP_IDLE;
      pre_reg <= '0;
      tick_reg <= 8'h00;
      tx_gap_end <= 1'b0;
    end else if (sys_ce) begin
      tx_gap_end <= 1'b0;
      if (take) begin
        // any byte restarts the gap count
        gap_st_reg <= term_use ? GAP_IDLE : GAP_WAIT;
        pre_reg <= '0;
        tick_reg <= 8'h00;
      end else begin
        unique case (gap_st_reg)
          GAP_IDLE: begin
            pre_reg <= '0;
          end
          GAP_WAIT: begin
            if (term_use) begin
              gap_st_reg <= GAP_IDLE; // mode left mid message
            end else if (tick_reg == r26) begin
              tx_gap_end <= 1'b1;
              gap_st_reg <= GAP_IDLE;
            end else if (pre_reg == `MSP_PRE_W'(TMO_UNIT_CYC - 1)) begin
              pre_reg <= '0;
              tick_reg <= tick_reg + 8'h01;
            end else begin
              pre_reg <= pre_reg + `MSP_PRE_W'(1);
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_wr18;
    sys_ce && cfg_wr && cfg_idx == `MSP_IDX_RADIO1 ##1 sys_ce;
  endsequence
  sequence s_wr19;
    sys_ce && cfg_wr && cfg_idx == `MSP_IDX_RADIO2 ##1 sys_ce;
  endsequence

  a_proto_decode: assert property (
    s_wr18 |=> proto_mode == $past(cfg_wdata[`MSP_F_PROTO], 2))
    else $error("protocol output does not follow write");
  a_binary_form: assert property (
    s_wr18 |=> tx_binary == $past(cfg_wdata[`MSP_B_FMT], 2))
    else $error("transmit form does not follow write");
  a_master_role: assert property (
    s_wr19 |=> master_beacon == $past(cfg_wdata[`MSP_B_MASTER], 2))
    else $error("beacon does not follow master bit");
  a_term_last: assert property (
    sys_ce && take && term_use && is_end |=> tx_valid && tx_last)
    else $error("terminator byte not marked last");
  a_src_drop: assert property (
    sys_ce && rx_hdr_valid && r18[`MSP_B_SRCCHK] && rx_hdr_src != r02
    |=> rx_drop && !rx_accept)
    else $error("foreign sender not discarded");
  a_dst_drop: assert property (
    sys_ce && rx_hdr_valid && r18[`MSP_B_DSTCHK] && !is_bc
    && rx_hdr_dst != r00 |=> rx_drop && !rx_accept)
    else $error("foreign destination not discarded");
  a_bcast_block: assert property (
    sys_ce && rx_hdr_valid && is_bc && proto_w == PROTO_PACKET
    && r19[`MSP_B_BCDIS] |=> rx_drop)
    else $error("broadcast taken while disabled");
  a_bcast_pass: assert property (
    sys_ce && rx_hdr_valid && rx_enabled && is_bc && !src_bad
    && !r19[`MSP_B_BCDIS] |=> rx_accept)
    else $error("broadcast refused");
  a_baud_9600: assert property (
    sys_ce && r20[`MSP_F_BAUD] == 4'h5
    |=> baud_ok && baud_div == 19'(`MSP_CLK_HZ / 9600))
    else $error("wrong divisor for 9600");
  a_crlf_stream: assert property (
    sys_ce && proto_w == PROTO_STREAM
    |=> rx_add_crlf == $past(r23[`MSP_B_CRLF]))
    else $error("stream CR LF choice wrong");
  a_crlf_packet: assert property (
    sys_ce && proto_w == PROTO_PACKET
    |=> rx_add_crlf == !$past(r23[`MSP_B_CRLF]))
    else $error("packet CR LF choice wrong");
  a_gap_mode: assert property (
    tx_gap_end |-> $past(proto_w == PROTO_STREAM && r26 != 8'h00))
    else $error("gap end outside stream mode");
endmodule
`default_nettype wire

// [msp_defines.svh]
// constants of the serial packet configuration bank
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH
`define MSP_NREG 28
`define MSP_IDX_W 5
`define MSP_IDX_LOCAL 5'h00
`define MSP_IDX_DEST 5'h02
`define MSP_IDX_CMDH 5'h0a
`define MSP_IDX_TERM1 5'h10
`define MSP_IDX_TERM2 5'h11
`define MSP_IDX_RADIO1 5'h12
`define MSP_IDX_RADIO2 5'h13
`define MSP_IDX_WIRED1 5'h14
`define MSP_IDX_WIRED2 5'h15
`define MSP_IDX_WIRED3 5'h16
`define MSP_IDX_WIRED4 5'h17
`define MSP_IDX_TMO 5'h1a
`define MSP_RV_01 8'hf0
`define MSP_RV_03 8'hf0
`define MSP_RV_07 8'h05
`define MSP_RV_08 8'hff
`define MSP_RV_09 8'h13
`define MSP_RV_10 8'h40
`define MSP_RV_11 8'h32
`define MSP_RV_12 8'hb4
`define MSP_RV_13 8'h1e
`define MSP_RV_14 8'h32
`define MSP_RV_16 8'h0d
`define MSP_RV_17 8'h0a
`define MSP_RV_18 8'h8c
`define MSP_RV_20 8'h05
`define MSP_RV_21 8'h09
`define MSP_RV_24 8'hc0
`define MSP_RV_25 8'h40
`define MSP_RV_ZERO 8'h00
`define MSP_F_PROTO 7:6
`define MSP_B_FMT 4
`define MSP_F_TERM 3:2
`define MSP_B_SRCCHK 1
`define MSP_B_DSTCHK 0
`define MSP_B_BCDIS 5
`define MSP_B_MASTER 1
`define MSP_B_DATA7 7
`define MSP_B_PAREN 6
`define MSP_B_PARODD 5
`define MSP_B_STOP2 4
`define MSP_F_BAUD 3:0
`define MSP_B_BRKHDR 4
`define MSP_B_HWFLOW 1
`define MSP_B_RXDIS 7
`define MSP_B_CRLF 4
`define MSP_CR 8'h0d
`define MSP_LF 8'h0a
`define MSP_BCAST 8'hff
`define MSP_CLK_HZ 125000000
`define MSP_CLK_NS 8
`define MSP_TMO_UNIT_NS 1000000
`define MSP_PRE_W 17
`define MSP_DIV_W 19
`endif

// [msp_pkg.sv]
// types of the serial packet configuration bank
`default_nettype none
package msp_pkg;
  typedef enum logic [1:0] {
    PROTO_TRANSP = 2'h0, PROTO_RSVD = 2'h1,
    PROTO_PACKET = 2'h2, PROTO_STREAM = 2'h3
  } msp_proto_t;
  typedef enum logic [1:0] {
    TERM_EITHER = 2'h0, TERM_WILD = 2'h1,
    TERM_PAIR = 2'h2, TERM_CRLF = 2'h3
  } msp_term_t;
  typedef enum logic [1:0] {
    GAP_IDLE = 2'b01, GAP_WAIT = 2'b10
  } msp_gap_st_t;
endpackage
`default_nettype wire

// [msp_pair_buf.sv]
// two-entry buffer with valid and ready on both sides
`include "msp_defines.svh"
`default_nettype none
module msp_pair_buf import msp_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic nrst, // sync reset, low
  input wire logic sys_ce, // clock enable
  input wire logic in_valid, // word offered
  input wire logic [7:0] in_data, // word in
  output logic in_ready, // room left
  output logic out_valid, // word held
  output logic [7:0] out_data, // oldest word
  input wire logic out_ready // drain side takes
);
  logic [7:0] mem_reg [0:1]; // two entries
  logic wr_ptr_reg; // write slot
  logic rd_ptr_reg; // read slot
  logic [1:0] cnt_reg; // entries held
  logic [1:0] cnt_next; // next fill level
  logic push; // word enters
  logic pop; // word leaves

  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  // fill level and registered ready
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_reg <= 2'h0;
      in_ready <= 1'b1;
    end else if (sys_ce) begin
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != 2'h2);
    end
  end

  // storage and pointers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else if (sys_ce) begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
    end
  end
endmodule
`default_nettype wire

// [msp_term_det.sv]
// terminator recogniser on the terminal input byte stream
`include "msp_defines.svh"
`default_nettype none
module msp_term_det import msp_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic nrst, // sync reset, low
  input wire logic sys_ce, // clock enable
  input wire msp_term_t term_sel, // terminator kind
  input wire logic [7:0] term1, // first code
  input wire logic [7:0] term2, // second code
  input wire logic byte_valid, // byte taken now
  input wire logic [7:0] byte_data, // byte value
  output logic is_end // byte closes packet
);
  logic prev_t1_reg; // last byte was first code
  logic prev_cr_reg; // last byte was carriage return

  // decide whether this byte ends the packet
  always_comb begin
    unique case (term_sel)
      TERM_EITHER: is_end = (byte_data == term1) || (byte_data == term2);
      TERM_WILD: is_end = prev_t1_reg; // any char after first
      TERM_PAIR: is_end = prev_t1_reg && (byte_data == term2);
      TERM_CRLF: is_end = prev_cr_reg && (byte_data == `MSP_LF);
    endcase
  end

  // remember leading byte, restart after an end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prev_t1_reg <= 1'b0;
      prev_cr_reg <= 1'b0;
    end else if (sys_ce && byte_valid) begin
      prev_t1_reg <= (byte_data == term1) && !is_end;
      prev_cr_reg <= (byte_data == `MSP_CR) && !is_end;
    end
  end
endmodule
`default_nettype wire

// [msp_term_model.sv]
// terminal equipment model feeding bytes into the bank
`default_nettype none
module msp_term_model (
  input wire logic sys_clk, // clock
  input wire logic in_ready, // bank takes byte
  output logic in_valid, // byte offered
  output logic [7:0] in_data // byte value
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
  end
  // offer a byte and hold it until the bank takes it
  task automatic send(input logic [7:0] b, output bit ok);
    int n;
    in_valid <= 1'b1;
    in_data <= b;
    ok = 1'b0;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge sys_clk);
      ok = in_ready;
    end
  endtask
  // release the line; idle data must not look like the last byte
  task automatic idle();
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench of the serial packet configuration bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, sys_ce = 1'b1, hold = 1'b0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, rx_hdr_valid = 1'b0, tx_ready = 1'b0;
  logic cmd_rx_enable = 1'b0, cmd_rx_disable = 1'b0, in_valid, in_ready;
  logic [4:0] cfg_idx = 5'h00;
  logic [7:0] cfg_wdata = 8'h00, rx_hdr_src = 8'h00, rx_hdr_dst = 8'h00;
  logic [7:0] in_data, cfg_rdata, tx_data, cmd_hdr_char;
  logic cfg_rvalid, cfg_err, tx_valid, tx_last, tx_gap_end, rx_accept;
  logic rx_drop, rx_enabled, rx_add_crlf, tx_binary, cmd_brk_hdr, baud_ok;
  logic data_7bit, parity_en, parity_odd, stop_2bit, hw_flow, master_beacon;
  logic [1:0] proto_mode;
  logic [18:0] baud_div;
  int err_count = 0, samples_checked = 0, seed = 4457;
  logic [8:0] rd_q[$], tx_q[$];
  logic [1:0] hd_q[$];
  logic [7:0] rv[12] = '{8'h0d, 8'h0a, 8'h8c, 8'h00, 8'h05, 8'h09,
                         8'h00, 8'h00, 8'hc0, 8'h40, 8'h00, 8'h00};
  logic [7:0] seq[6] = '{8'h0d, 8'h0a, 8'h41, 8'h0a, 8'h0d, 8'h41};
  logic [5:0] msk[4] = '{6'h36, 6'h11, 6'h10, 6'h10};
  msp_cfg_bank #(.TMO_UNIT_CYC(4)) uut (.sys_clk, .nrst, .sys_ce, .cfg_wr,
    .cfg_rd, .cfg_idx, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_err,
    .cmd_rx_enable, .cmd_rx_disable, .in_valid, .in_data, .in_ready,
    .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_gap_end, .rx_hdr_valid,
    .rx_hdr_src, .rx_hdr_dst, .rx_accept, .rx_drop, .rx_enabled,
    .rx_add_crlf, .tx_binary, .proto_mode, .cmd_brk_hdr, .cmd_hdr_char,
    .data_7bit, .parity_en, .parity_odd, .stop_2bit, .baud_div, .baud_ok,
    .hw_flow, .master_beacon);
  msp_term_model term (.sys_clk, .in_ready, .in_valid, .in_data);
  always #4 sys_clk = ~sys_clk;
  // radio side stalls at random, or fully while hold is set
  always @(posedge sys_clk)
    tx_ready <= nrst && !hold && 1'($random(seed));
  task automatic chk(string what, logic [23:0] e, logic [23:0] g);
    samples_checked++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask
  // oldest note off each queue whenever a result appears
  always @(posedge sys_clk) begin
    if (cfg_rvalid | cfg_err)
      chk("cfg_rdata", rd_q.pop_front(), {cfg_err, cfg_rdata});
    if (tx_valid & tx_ready)
      chk("tx_byte", tx_q.pop_front(), {tx_last, tx_data});
    if (rx_accept | rx_drop)
      chk("verdict", hd_q.pop_front(), {rx_accept, rx_drop});
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic int nleft();
    return tx_q.size() + rd_q.size() + hd_q.size();
  endfunction
  task automatic drain();
    for (int n = 0; n < 300 && nleft() != 0; n++)
      @(posedge sys_clk);
    chk("queues", 0, nleft());
    if (nleft() != 0)
      end_of_test();
  endtask
  // register write; returns once decoded outputs have settled
  task automatic wr(logic [4:0] i, logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(logic [4:0] i, logic [8:0] e);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_idx <= i;
    rd_q.push_back(e);
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
  endtask
  task automatic hdr(logic [7:0] s, logic [7:0] d, logic a);
    @(posedge sys_clk);
    rx_hdr_valid <= 1'b1;
    rx_hdr_src <= s;
    rx_hdr_dst <= d;
    hd_q.push_back({a, !a});
    @(posedge sys_clk);
    rx_hdr_valid <= 1'b0;
  endtask
  task automatic snd(logic [7:0] b, logic l);
    bit ok;
    tx_q.push_back({l, b});
    term.send(b, ok);
    chk("in_ready", 1'b1, ok);
    if (!ok)
      end_of_test();
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("dflt", 23'h5832dc, {proto_mode, rx_add_crlf,
        rx_enabled, baud_div});
    chk("hdr_char", 8'h40, cmd_hdr_char);
    foreach (rv[k]) rd(5'(k + 16), {1'b0, rv[k]});
    rd(5'h1c, 9'h100);
    wr(5'h14, 8'hfd);
    chk("fmt", 24'hf8043d, {data_7bit, parity_en,
        parity_odd, stop_2bit, baud_ok, baud_div});
    wr(5'h14, 8'h2c);
    chk("fmt", 24'h08087a, {data_7bit, parity_en,
        parity_odd, stop_2bit, baud_ok, baud_div});
    wr(5'h14, 8'h08);
    chk("rsvd_baud", 20'h0, {baud_ok, baud_div});
    rd(5'h14, 9'h008);
    wr(5'h15, 8'h1b);
    chk("hdr_flow", 2'h3, {cmd_brk_hdr, hw_flow});
    wr(5'h13, 8'h02);
    chk("master", 1'b1, master_beacon);
    wr(5'h13, 8'h00);
    wr(5'h12, 8'h9c);
    chk("binary", 1'b1, tx_binary);
    wr(5'h17, 8'h10);
    chk("crlf_pkt", 1'b0, rx_add_crlf);
    wr(5'h12, 8'hcc);
    chk("crlf_strm", 3'h7, {proto_mode, rx_add_crlf});
    wr(5'h17, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(5'h12, 8'h80 | 8'(m << 2));
      snd(8'h20 | 8'($random(seed)), 1'b0);
      for (int j = 0; j < 6; j++) snd(seq[j], msk[m][5 - j]);
      term.idle();
      drain();
    end
    wr(5'h12, 8'hcc);
    wr(5'h1a, 8'h01);
    snd(8'h0d, 1'b0);
    snd(8'h0a, 1'b0);
    term.idle();
    for (int n = 0; n < 40 && tx_gap_end !== 1'b1; n++) @(posedge sys_clk);
    chk("gap_end", 1'b1, tx_gap_end);
    wr(5'h1a, 8'h00);
    wr(5'h12, 8'h8f);
    wr(5'h00, 8'h05);
    wr(5'h02, 8'h07);
    hdr(8'h07, 8'h05, 1'b1);
    hdr(8'h08, 8'h05, 1'b0);
    hdr(8'h07, 8'h06, 1'b0);
    hdr(8'h07, 8'hff, 1'b1);
    wr(5'h13, 8'h20);
    hdr(8'h07, 8'hff, 1'b0);
    cmd_rx_disable <= 1'b1;
    @(posedge sys_clk);
    cmd_rx_disable <= 1'b0;
    hdr(8'h07, 8'h05, 1'b0);
    cmd_rx_enable <= 1'b1;
    @(posedge sys_clk);
    cmd_rx_enable <= 1'b0;
    hdr(8'h07, 8'h05, 1'b1);
    // a write while the clock enable is low must not land
    @(posedge sys_clk);
    sys_ce <= 1'b0;
    wr(5'h13, 8'h22);
    sys_ce <= 1'b1;
    chk("frozen", 1'b0, master_beacon);
    rd(5'h13, 9'h020);
    // stall the radio side until the buffer refuses
    hold <= 1'b1;
    fork
      for (int k = 0; k < 4; k++) snd(8'h30 + 8'(k), 1'b0);
      begin
        repeat (12) @(posedge sys_clk);
        chk("full", 1'b0, in_ready);
        hold <= 1'b0;
      end
    join
    term.idle();
    drain();
    end_of_test();
  end
endmodule
`default_nettype wire
